// ===== core/slpbt_gen.sv
// per-lane prbs generator with comma start-up and clock compensation
`timescale 1ns/1ps
`default_nettype none
module slpbt_gen
  import slpbt_pkg::*;
(
  input  wire logic           pclk,
  input  wire logic           presetn,
  input  wire logic           step,
  input  wire slpbt_gen_cfg_s cfg,
  output logic                tx_bit
);
  slpbt_gen_s  s;
  slpbt_gen_s  n;
  logic        fb;
  logic [22:0] pb;
  logic [10:0] ev;
  logic [9:0]  cw;

  always_comb
  begin
    n = s;
    fb = 1'b0;
    pb = '0;
    ev = '0;
    cw = '0;
    if (!cfg.run)
    begin
      n = GEN_RST; // see RULE_16
      n.lfsr = cfg.seed;
    end
    else if (step && cfg.one_way_select)
    begin
      fb = prbs_fb(s.lfsr, cfg.pattern); // see RULE_03
      n.lfsr = {s.lfsr[13:0], fb};
      n.bit_o = fb;
    end
    else if (step && s.bcnt != 4'h0)
    begin
      n.sh = {s.sh[8:0], 1'b0};
      n.bit_o = s.sh[9];
      n.bcnt = s.bcnt - 4'h1;
    end
    else if (step)
    begin
      unique case (s.phase)
        GEN_IDLE, GEN_COMMA:
        begin
          cw = s.rd ? K28_5_POS : K28_5_NEG; // see RULE_07
          n.rd = ~s.rd;
          n.phase = GEN_COMMA;
          n.ncomma = s.ncomma + 6'h1;
          if (s.ncomma == COMMA_START - 6'h1)
            n.phase = GEN_DATA;
        end
        GEN_DATA:
        begin
          pb = prbs_byte(s.lfsr, cfg.pattern);
          ev = enc8b10b(pb[7:0], s.rd); // see RULE_06
          cw = ev[9:0];
          n.rd = ev[10];
          n.lfsr = pb[22:8];
          n.ncg = s.ncg + 13'h1;
          if (s.ncg == CC_PERIOD - 13'h1)
          begin
            n.phase = GEN_CLKC; // see RULE_08
            n.ncg = '0;
            n.ncc = '0;
          end
        end
        GEN_CLKC:
        begin
          // K then three neutral R
          if (s.ncc == 2'h0)
          begin
            cw = s.rd ? K28_5_POS : K28_5_NEG;
            n.rd = ~s.rd;
          end
          else
            cw = s.rd ? K29_7_POS : K29_7_NEG;
          n.ncc = s.ncc + 2'h1;
          if (s.ncc == 2'h3)
            n.phase = GEN_DATA;
        end
      endcase
      n.sh = {cw[8:0], 1'b0};
      n.bit_o = cw[9];
      n.bcnt = CG_LAST;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      s <= GEN_RST;
    else
      s <= n;
  end

  assign tx_bit = s.bit_o;
endmodule // slpbt_gen
`default_nettype wire

// ===== core/slpbt_pkg.sv
// shared constants, types and coding functions of the lane bert block
package slpbt_pkg;
  localparam int unsigned NLANE = 4;
  // apb map
  localparam logic [7:0] OFS_PORT    = 8'h00;
  localparam logic [7:0] OFS_LANE0   = 8'h20;
  localparam logic [4:0] OFS_CTL     = 5'h00;
  localparam logic [4:0] OFS_SEED    = 5'h04;
  localparam logic [4:0] OFS_ERR     = 5'h08;
  localparam logic [4:0] OFS_SERDES  = 5'h0c;
  localparam logic [4:0] OFS_BITS    = 5'h10;
  localparam int unsigned ALIGNED_POS = 8;
  localparam int unsigned ACTIVE_POS  = 9;
  // reset values and codes
  localparam logic [1:0]  FPW_RST     = 2'h0;
  localparam logic [1:0]  FPW_1X      = 2'h2;
  localparam logic [14:0] SEED_RST    = 15'h7fff;
  localparam logic [31:0] CNT_MAX     = 32'hffff_ffff;
  localparam logic [31:0] BITS_PER_CG = 32'h0000_000a;
  // timing counts, in code-groups or bits
  localparam logic [12:0] CC_PERIOD   = 13'h1388;
  localparam logic [5:0]  COMMA_START = 6'h20;
  localparam logic [3:0]  CG_LAST     = 4'h9;
  localparam logic [2:0]  LOS_MISSES  = 3'h4;
  // special code-groups, bit 9 is sent first
  localparam logic [9:0] K28_5_NEG = 10'h0fa;
  localparam logic [9:0] K28_5_POS = 10'h305;
  localparam logic [9:0] K29_7_NEG = 10'h2e8;
  localparam logic [9:0] K29_7_POS = 10'h117;
  localparam logic [6:0] COMMA_NEG = 7'h1f;
  localparam logic [6:0] COMMA_POS = 7'h60;
  localparam logic [5:0] ENC6 [0:31] = '{
    6'h27, 6'h1d, 6'h2d, 6'h31, 6'h35, 6'h29, 6'h19, 6'h38,
    6'h39, 6'h25, 6'h15, 6'h34, 6'h0d, 6'h2c, 6'h1c, 6'h17,
    6'h1b, 6'h23, 6'h13, 6'h32, 6'h0b, 6'h2a, 6'h1a, 6'h3a,
    6'h33, 6'h26, 6'h16, 6'h36, 6'h0e, 6'h2e, 6'h1e, 6'h2b};
  localparam logic [3:0] ENC4 [0:7] = '{
    4'hb, 4'h9, 4'h5, 4'hc, 4'hd, 4'ha, 4'h6, 4'he};
  localparam logic [3:0] ALT7_NEG = 4'h7;

  typedef struct packed {
    logic pattern;
    logic one_way_select;
    logic train;
    logic transmit;
    logic enable;
  } slpbt_ctl_s;

  typedef struct packed {
    logic rx_invert;
    logic rx_clock_loop_on;
    logic rx_data_path_on;
    logic termination_on;
    logic aligner_on;
    logic receiver_on;
    logic rate_divide_by_two;
    logic pma_wrap_on;
    logic tx_invert;
    logic tx_data_path_on;
    logic transmitter_on;
    logic common_mode_on;
    logic lane_tx_power;
  } slpbt_serdes_s;

  typedef struct packed {
    logic        run;
    logic        one_way_select;
    logic        pattern;
    logic [14:0] seed;
  } slpbt_gen_cfg_s;

  typedef enum logic [1:0] {
    GEN_IDLE  = 2'b00,
    GEN_COMMA = 2'b01,
    GEN_DATA  = 2'b10,
    GEN_CLKC  = 2'b11
  } slpbt_gen_e;

  typedef struct packed {
    slpbt_gen_e  phase;
    logic [14:0] lfsr;
    logic [9:0]  sh;
    logic [3:0]  bcnt;
    logic        rd;
    logic [5:0]  ncomma;
    logic [12:0] ncg;
    logic [1:0]  ncc;
    logic        bit_o;
  } slpbt_gen_s;

  typedef struct packed {
    logic [14:0] lfsr;
    logic [9:0]  win;
    logic [3:0]  bcnt;
    logic        aligned;
    logic [2:0]  nmiss;
  } slpbt_chk_s;

  typedef struct packed {
    logic [NLANE:0] meta;
    logic [NLANE:0] held;
  } slpbt_sync_s;

  typedef struct packed {
    logic [1:0]                  fpw;
    slpbt_ctl_s    [NLANE-1:0]   ctl;
    logic          [NLANE-1:0][14:0] seed;
    slpbt_serdes_s [NLANE-1:0]   sd;
    logic          [NLANE-1:0][31:0] err;
    logic          [NLANE-1:0][31:0] bits;
    slpbt_chk_s    [NLANE-1:0]   chk;
    logic          [NLANE-1:0]   half;
    logic                        lk_prev;
    logic          [NLANE-1:0]   txo;
    logic          [NLANE-1:0]   drv;
    logic [31:0]                 prdata;
  } slpbt_top_s;

  localparam slpbt_gen_s GEN_RST = '{phase: GEN_IDLE, default: '0};
  localparam slpbt_top_s TOP_RST = '{fpw: FPW_RST,
                                     seed: {NLANE{SEED_RST}},
                                     default: '0};

  // pattern 0: x^7+x^6+1, pattern 1: x^15+x^14+1
  function automatic logic prbs_fb(input logic [14:0] s,
                                   input logic pat);
    return pat ? (s[14] ^ s[13]) : (s[6] ^ s[5]);
  endfunction

  // eight steps; returns {next state, byte}
  function automatic logic [22:0] prbs_byte(input logic [14:0] s,
                                            input logic pat);
    logic [14:0] t;
    logic [7:0]  b;
    logic        f;
    t = s;
    b = 8'h00;
    for (int k = 0; k < 8; k++)
    begin
      f = prbs_fb(t, pat);
      t = {t[13:0], f};
      b = {b[6:0], f};
    end
    return {t, b};
  endfunction

  // all-zero state locks up
  function automatic logic [14:0] seed_fix(input logic [14:0] s,
                                           input logic pat);
    if (pat ? (s == 15'h0000) : (s[6:0] == 7'h00))
      return SEED_RST;
    return s;
  endfunction

  // data character encode; returns {disparity out, abcdei fghj}
  function automatic logic [10:0] enc8b10b(input logic [7:0] d,
                                           input logic rd);
    logic [5:0] c6;
    logic [3:0] c4;
    logic       r;
    logic       alt;
    c6 = ENC6[d[4:0]];
    r = rd;
    if (r && (($countones(c6) != 3) || (d[4:0] == 5'h07)))
      c6 = ~c6;
    if ($countones(c6) != 3)
      r = ~r;
    alt = r ? (d[4:0] == 5'h0b || d[4:0] == 5'h0d || d[4:0] == 5'h0e)
            : (d[4:0] == 5'h11 || d[4:0] == 5'h12 || d[4:0] == 5'h14);
    c4 = (d[7:5] == 3'h7 && alt) ? ALT7_NEG : ENC4[d[7:5]];
    if (r && (($countones(c4) != 2) || (d[7:5] == 3'h3)))
      c4 = ~c4;
    if ($countones(c4) != 2)
      r = ~r;
    return {r, c6, c4};
  endfunction

  function automatic logic is_comma(input logic [6:0] w);
    return (w == COMMA_NEG) || (w == COMMA_POS);
  endfunction

  function automatic logic is_kcode(input logic [9:0] w);
    return (w == K28_5_NEG) || (w == K28_5_POS) ||
           (w == K29_7_NEG) || (w == K29_7_POS);
  endfunction
endpackage

// ===== core/slpbt_sync.sv
// two-flop synchroniser for the link clock and receive pins
`timescale 1ns/1ps
`default_nettype none
module slpbt_sync
  import slpbt_pkg::*;
(
  input  wire logic           pclk,
  input  wire logic           presetn,
  input  wire logic [NLANE:0] d,
  output logic      [NLANE:0] q
);
  slpbt_sync_s s_q;
  slpbt_sync_s s_d;

  always_comb
  begin
    s_d.meta = d;
    s_d.held = s_q.meta;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      s_q <= '0;
    else
      s_q <= s_d;
  end

  assign q = s_q.held;
endmodule // slpbt_sync
`default_nettype wire

// ===== core/slpbt_top.sv
// per-lane prbs bit error rate tester with its apb register file
// Behaviour
// RULE_01: per-lane select between one-way and loopback test
// RULE_02: partner runs matching generator or checker one-way
// RULE_03: one-way mode sends raw prbs, encoder bypassed
// RULE_04: one-way checker compares raw received bits
// RULE_05: loopback runs generator and checker together
// RULE_06: loopback prbs bytes pass the 8b/10b encoder
// RULE_07: loopback start sends commas before prbs data
// RULE_08: every 5000 code-groups insert K R R R
// RULE_09: lanes run only with port width forced 1x
// RULE_10: operator powers transmitter, may invert or wrap
// RULE_11: operator halves rate for 1.25 Gbaud only
// RULE_12: operator disables aligner for one-way receive
// RULE_13: clear error count and load seed first
// RULE_14: configure with transmit low, raise it to start
// RULE_15: clearing train starts error counting
// RULE_16: transmit low stops generator, freezes counter
// RULE_17: operator stops other lanes before lane 0
// RULE_18: link rate change needs a device reset
// RULE_19: one line error may give two code errors
// RULE_20: error counter saturates instead of wrapping
`timescale 1ns/1ps
`default_nettype none
module slpbt_top
  import slpbt_pkg::*;
(
  input  wire logic             pclk,
  input  wire logic             presetn,
  input  wire logic [7:0]       paddr,
  input  wire logic             psel,
  input  wire logic             penable,
  input  wire logic             pwrite,
  input  wire logic [31:0]      pwdata,
  output logic      [31:0]      prdata,
  output logic                  pready,
  output logic                  pslverr,
  input  wire logic             link_clk,
  input  wire logic [NLANE-1:0] rx_serial,
  output logic      [NLANE-1:0] tx_serial,
  output logic      [NLANE-1:0] tx_drive
);
  slpbt_top_s                  s;
  slpbt_top_s                  n;
  logic           [NLANE:0]    pins;
  logic                        edge_seen;
  logic           [NLANE-1:0]  run;
  logic           [NLANE-1:0]  tick;
  logic           [NLANE-1:0]  rx_ok;
  logic           [NLANE-1:0]  tx_ok;
  logic           [NLANE-1:0]  rbit;
  logic           [NLANE-1:0]  gen_bit;
  slpbt_gen_cfg_s [NLANE-1:0]  gcfg;
  logic                        acc;
  logic                        hit;

  function automatic logic lane_hit(input logic [7:0] a);
    logic [2:0] l;
    l = a[7:5] - OFS_LANE0[7:5];
    return (a[7:5] >= OFS_LANE0[7:5]) && (l < 3'(NLANE));
  endfunction

  function automatic logic [1:0] lane_of(input logic [7:0] a);
    logic [2:0] l;
    l = a[7:5] - OFS_LANE0[7:5];
    return l[1:0];
  endfunction

  function automatic logic addr_ok(input logic [7:0] a);
    logic [4:0] r;
    r = a[4:0];
    if (a == OFS_PORT)
      return 1'b1;
    return lane_hit(a) && (r == OFS_CTL || r == OFS_SEED ||
           r == OFS_ERR || r == OFS_SERDES || r == OFS_BITS);
  endfunction

  function automatic logic [31:0] sat_add(input logic [31:0] v,
                                          input logic [31:0] inc);
    if (CNT_MAX - v < inc)
      return CNT_MAX; // see RULE_20
    return v + inc;
  endfunction

  // link clock and rx pins are asynchronous
  slpbt_sync u_sync (
    .pclk    (pclk),
    .presetn (presetn),
    .d       ({link_clk, rx_serial}),
    .q       (pins)
  );

  assign edge_seen = pins[NLANE] & ~s.lk_prev;
  assign acc       = psel & penable;
  assign hit       = addr_ok(paddr);

  for (genvar i = 0; i < NLANE; i++)
  begin : g_lane
    assign run[i] = s.ctl[i].enable & s.ctl[i].transmit &
                    (s.fpw == FPW_1X); // see RULE_09 see RULE_14
    // halved rate uses every other link edge
    assign tick[i] = edge_seen &
                     (~s.sd[i].rate_divide_by_two | s.half[i]); // see RULE_11
    assign tx_ok[i] = s.sd[i].lane_tx_power & s.sd[i].common_mode_on &
                      s.sd[i].transmitter_on &
                      s.sd[i].tx_data_path_on; // see RULE_10
    assign rx_ok[i] = s.sd[i].receiver_on & s.sd[i].termination_on &
                      s.sd[i].rx_data_path_on;
    // wrap loops the registered line level
    assign rbit[i] = (s.sd[i].pma_wrap_on ? s.txo[i] : pins[i]) ^
                     s.sd[i].rx_invert; // see RULE_05
    assign gcfg[i] = '{run: run[i],
                       one_way_select: s.ctl[i].one_way_select,
                       pattern: s.ctl[i].pattern,
                       seed: seed_fix(s.seed[i], s.ctl[i].pattern)};

    slpbt_gen u_gen (
      .pclk    (pclk),
      .presetn (presetn),
      .step    (tick[i]),
      .cfg     (gcfg[i]),
      .tx_bit  (gen_bit[i])
    );
  end

  always_comb
  begin
    logic [NLANE-1:0] clr_err;
    logic [NLANE-1:0] clr_bits;
    logic [1:0]       wl;
    slpbt_chk_s       c;
    logic             fb;
    logic             miss;
    logic             chk_cg;
    logic             cmatch;
    logic [22:0]      pb;
    logic [10:0]      e0;
    logic [10:0]      e1;
    logic [14:0]      sd0;
    logic [31:0]      rdw;
    logic [31:0]      ev;
    logic [31:0]      bv;
    clr_err = '0;
    clr_bits = '0;
    wl = lane_of(paddr);
    c = '0;
    fb = 1'b0;
    miss = 1'b0;
    chk_cg = 1'b0;
    cmatch = 1'b0;
    pb = '0;
    e0 = '0;
    e1 = '0;
    sd0 = '0;
    rdw = 32'h0000_0000;
    ev = 32'h0000_0000;
    bv = 32'h0000_0000;
    n = s;
    n.lk_prev = pins[NLANE];

    // read data latched in setup, valid in access
    if (paddr == OFS_PORT)
      rdw[1:0] = s.fpw;
    else if (hit)
    begin
      case (paddr[4:0])
        OFS_CTL:
        begin
          rdw[$bits(slpbt_ctl_s)-1:0] = s.ctl[wl];
          rdw[ALIGNED_POS] = s.chk[wl].aligned;
          rdw[ACTIVE_POS] = run[wl];
        end
        OFS_SEED:   rdw[14:0] = s.seed[wl];
        OFS_ERR:    rdw = s.err[wl];
        OFS_SERDES: rdw[$bits(slpbt_serdes_s)-1:0] = s.sd[wl];
        OFS_BITS:   rdw = s.bits[wl];
        default:    rdw = 32'h0000_0000;
      endcase
    end
    if (psel && !penable && !pwrite)
      n.prdata = rdw;

    if (acc && pwrite && hit)
    begin
      if (paddr == OFS_PORT)
        n.fpw = pwdata[1:0]; // see RULE_09
      else
      begin
        case (paddr[4:0])
          OFS_CTL:
            n.ctl[wl] = pwdata[$bits(slpbt_ctl_s)-1:0]; // see RULE_01
          OFS_SEED:
            n.seed[wl] = pwdata[14:0]; // see RULE_13
          OFS_ERR:
            clr_err[wl] = 1'b1; // see RULE_13
          OFS_SERDES:
            n.sd[wl] = pwdata[$bits(slpbt_serdes_s)-1:0];
          OFS_BITS:
            clr_bits[wl] = 1'b1;
          default:
            n.fpw = s.fpw;
        endcase
      end
    end

    for (int i = 0; i < NLANE; i++)
    begin
      c = s.chk[i];
      miss = 1'b0;
      chk_cg = 1'b0;
      sd0 = seed_fix(s.seed[i], s.ctl[i].pattern);
      n.half[i] = s.half[i] ^ edge_seen;
      n.drv[i] = tx_ok[i];
      n.txo[i] = tx_ok[i] & (gen_bit[i] ^ s.sd[i].tx_invert);
      if (!run[i])
      begin
        // idle lane: checker restarts from seed
        c.lfsr = sd0;
        c.win = '0;
        c.bcnt = '0;
        c.aligned = 1'b0;
        c.nmiss = '0;
      end
      else if (tick[i] && rx_ok[i] && s.ctl[i].one_way_select)
      begin
        // training self-seeds from the line
        fb = prbs_fb(c.lfsr, s.ctl[i].pattern); // see RULE_04
        c.lfsr = {c.lfsr[13:0], s.ctl[i].train ? rbit[i] : fb};
        miss = (rbit[i] != fb) & ~s.ctl[i].train; // see RULE_15
        chk_cg = ~s.ctl[i].train;
      end
      else if (tick[i] && rx_ok[i])
      begin
        c.win = {c.win[8:0], rbit[i]};
        // aligner off means no lock in loopback
        cmatch = s.sd[i].aligner_on & is_comma(c.win[9:3]); // see RULE_12
        if (cmatch && (!c.aligned || c.bcnt != CG_LAST))
        begin
          c.aligned = 1'b1;
          c.bcnt = '0;
          c.nmiss = '0;
        end
        else if (c.aligned && c.bcnt == CG_LAST)
        begin
          c.bcnt = '0;
          if (!is_kcode(c.win))
          begin
            pb = prbs_byte(c.lfsr, s.ctl[i].pattern);
            e0 = enc8b10b(pb[7:0], 1'b0);
            e1 = enc8b10b(pb[7:0], 1'b1);
            // either disparity accepted: no decoder needed
            if (c.win == e0[9:0] || c.win == e1[9:0])
            begin
              c.lfsr = pb[22:8];
              c.nmiss = '0;
            end
            else if (s.ctl[i].train)
              c.lfsr = sd0;
            else
            begin
              // one line error can spoil one or two code-groups
              c.lfsr = pb[22:8]; // see RULE_19
              miss = 1'b1;
              c.nmiss = c.nmiss + 3'h1;
              if (c.nmiss == LOS_MISSES)
              begin
                c.aligned = 1'b0;
                c.nmiss = '0;
              end
            end
            chk_cg = ~s.ctl[i].train;
          end
        end
        else if (c.aligned)
          c.bcnt = c.bcnt + 4'h1;
      end
      n.chk[i] = c;

      // error wins over a same-cycle clear
      ev = clr_err[i] ? 32'h0000_0000 : s.err[i];
      n.err[i] = miss ? sat_add(ev, 32'h0000_0001) : ev; // see RULE_16
      bv = clr_bits[i] ? 32'h0000_0000 : s.bits[i];
      if (chk_cg)
        bv = sat_add(bv, s.ctl[i].one_way_select ? 32'h0000_0001
                                                  : BITS_PER_CG);
      n.bits[i] = bv;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      s <= TOP_RST;
    else
      s <= n;
  end

  assign prdata    = s.prdata;
  assign pready    = 1'b1;
  assign pslverr   = acc & ~hit;
  assign tx_serial = s.txo;
  assign tx_drive  = s.drv;
endmodule // slpbt_top
`default_nettype wire

// ===== dv/slpbt_checker.sv
// port assertions for the lane bert block
`timescale 1ns/1ps
`default_nettype none
module slpbt_checker
  import slpbt_pkg::*;
(
  input wire logic             pclk,
  input wire logic             presetn,
  input wire logic [7:0]       paddr,
  input wire logic             psel,
  input wire logic             penable,
  input wire logic             pwrite,
  input wire logic [31:0]      prdata,
  input wire logic             pready,
  input wire logic             pslverr,
  input wire logic             link_clk,
  input wire logic [NLANE-1:0] tx_serial,
  input wire logic [NLANE-1:0] tx_drive
);
  logic [3:0] wr_age_q;
  logic [3:0] lk_age_q;
  logic       lk_q;
  logic       acc;
  logic       mapped;
  assign acc = psel && penable;
  assign mapped = (paddr == 8'h00) || (paddr[7:5] != 3'h0 &&
    paddr[7:5] <= 3'h4 && paddr[4:0] <= 5'h10 && paddr[1:0] == 2'h0);
  // ages saturate, never wrap to zero
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      wr_age_q <= 4'hf;
      lk_age_q <= 4'hf;
      lk_q     <= 1'b0;
    end
    else
    begin
      lk_q     <= link_clk;
      wr_age_q <= (acc && pwrite) ? 4'h0
                : wr_age_q + {3'h0, wr_age_q != 4'hf};
      lk_age_q <= (link_clk && !lk_q) ? 4'h0
                : lk_age_q + {3'h0, lk_age_q != 4'hf};
    end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_zero_wait: assert property (acc |-> pready)
    else $error("pready low in access phase");
  a_err_phase: assert property (pslverr |-> acc)
    else $error("pslverr outside access phase");
  a_err_map: assert property (acc |-> pslverr == !mapped)
    else $error("pslverr does not match the map");
  a_err_rd_zero: assert property
    (acc && !pwrite && pslverr |-> prdata == 32'h0000_0000)
    else $error("unmapped read not zero");
  a_rd_stands: assert property
    (!$past(psel && !penable) |-> $stable(prdata))
    else $error("prdata moved without a setup");
  a_idle_low: assert property ((tx_serial & ~tx_drive) == '0)
    else $error("undriven lane not low");
  a_drive_cause: assert property
    ($changed(tx_drive) |-> wr_age_q <= 4'h2)
    else $error("tx_drive moved without a write");
  a_tx_on_tick: assert property
    ($changed(tx_serial) && wr_age_q > 4'h6 |-> lk_age_q inside {[2:6]})
    else $error("tx bit moved off the link tick");
  c_unmapped: cover property (acc && pslverr);
  c_drive_on: cover property ($rose(tx_drive[0]));
  c_tx_bits: cover property ($changed(tx_serial[1]));
endmodule // slpbt_checker
bind slpbt_top slpbt_checker i_chk (.pclk, .presetn, .paddr, .psel,
  .penable, .pwrite, .prdata, .pready, .pslverr, .link_clk,
  .tx_serial, .tx_drive);
`default_nettype wire

// ===== dv/slpbt_partner.sv
// link partner: loops each driven lane back, flipping bits on request
`timescale 1ns/1ps
`default_nettype none
module slpbt_partner
  import slpbt_pkg::*;
(
  input  wire logic             link_clk,
  input  wire logic [NLANE-1:0] tx_serial,
  input  wire logic [NLANE-1:0] tx_drive,
  input  wire logic [NLANE-1:0] flip,
  output var logic  [NLANE-1:0] rx_serial
);
  initial rx_serial = '0;
  // released lane toggles: no stale bit
  always @(posedge link_clk)
    rx_serial <= (tx_drive & (tx_serial ^ flip))
               | (~tx_drive & ~rx_serial);
endmodule // slpbt_partner
`default_nettype wire

// ===== dv/testbench.sv
// testbench for the lane bert block with a looping partner
`timescale 1ns/1ps
`default_nettype none
module testbench
  import slpbt_pkg::*;
;
  typedef struct packed {
    logic [7:0]  a;
    logic        w;
    logic [31:0] d;
    logic [31:0] q;
    logic        e;
  } slpbt_row_s;
  logic             pclk = 1'b0;
  logic             presetn = 1'b0;
  logic             link_clk = 1'b0;
  logic [7:0]       paddr = '0;
  logic             psel = 1'b0;
  logic             penable = 1'b0;
  logic             pwrite = 1'b0;
  logic [31:0]      pwdata = '0;
  logic [31:0]      prdata;
  logic             pready;
  logic             pslverr;
  logic [NLANE-1:0] rx_serial;
  logic [NLANE-1:0] tx_serial;
  logic [NLANE-1:0] tx_drive;
  logic [NLANE-1:0] flip = '0;
  logic             last_err;
  logic [31:0]      r;
  logic [31:0]      keep;
  logic [9:0]       cg;
  logic [47:0]      hist;
  int               fail_count = 0;
  int               samples_checked = 0;
  int               n;
  slpbt_row_s rows [11] = '{
    '{8'h00, 1'b0, 32'h0000_0000, 32'h0000_0000, 1'b0},
    '{8'h24, 1'b0, 32'h0000_0000, 32'h0000_7fff, 1'b0},
    '{8'h8c, 1'b0, 32'h0000_0000, 32'h0000_0000, 1'b0},
    '{8'h60, 1'b0, 32'h0000_0000, 32'h0000_0000, 1'b0},
    '{8'h48, 1'b0, 32'h0000_0000, 32'h0000_0000, 1'b0},
    '{8'h44, 1'b1, 32'h0000_1234, 32'h0000_0000, 1'b0},
    '{8'h44, 1'b0, 32'h0000_0000, 32'h0000_1234, 1'b0},
    '{8'h14, 1'b0, 32'h0000_0000, 32'h0000_0000, 1'b1},
    '{8'ha0, 1'b1, 32'hffff_ffff, 32'h0000_0000, 1'b1},
    '{8'h00, 1'b1, 32'hffff_ffff, 32'h0000_0000, 1'b0},
    '{8'h00, 1'b0, 32'h0000_0000, 32'h0000_0003, 1'b0}};
  always #50 pclk = ~pclk;
  // offset: link edges never meet pclk edges
  initial
  begin
    #130;
    forever #400 link_clk = ~link_clk;
  end
  slpbt_top i_dut (.pclk, .presetn, .paddr, .psel, .penable, .pwrite,
    .pwdata, .prdata, .pready, .pslverr, .link_clk, .rx_serial,
    .tx_serial, .tx_drive);
  slpbt_partner i_peer (.link_clk, .tx_serial, .tx_drive, .flip,
    .rx_serial);
  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    samples_checked++;
    if (g !== e)
    begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic give_up(input string nm);
    chk(nm, 32'h0000_0001, 32'h0000_0000);
    wrap_up();
  endtask
  task automatic apb(input logic [7:0] a, input logic w,
                     input logic [31:0] d);
    int k;
    k = 0;
    @(posedge pclk);
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    psel <= 1'b1;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1)
    begin
      k++;
      if (k > 50)
        give_up("pready wait");
      @(posedge pclk);
    end
    r = prdata;
    last_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  function automatic logic [7:0] la(input int l, input logic [4:0] o);
    return {l[2:0] + 3'h1, o};
  endfunction
  task automatic wr(input int l, input logic [4:0] o,
                    input logic [31:0] d);
    apb(la(l, o), 1'b1, d);
  endtask
  task automatic rd(input int l, input logic [4:0] o);
    apb(la(l, o), 1'b0, 32'h0000_0000);
  endtask
  task automatic grab(input int l, input int nb);
    repeat (nb)
    begin
      @(posedge link_clk);
      hist = {hist[46:0], tx_serial[l]};
    end
    cg = hist[9:0];
  endtask
  task automatic hit(input int l);
    @(posedge link_clk);
    @(posedge pclk);
    flip[l] <= 1'b1;
    @(posedge link_clk);
    @(posedge pclk);
    flip[l] <= 1'b0;
  endtask
  initial
  begin
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    foreach (rows[i])
    begin
      apb(rows[i].a, rows[i].w, rows[i].d);
      if (!rows[i].w)
        chk("rdata", rows[i].q, r);
      chk("pslverr", {31'h0, rows[i].e}, {31'h0, last_err});
    end
    // width field is 3, not 1x: lane must stay quiet
    wr(0, OFS_SERDES, 32'h0000_0f8f);
    wr(0, OFS_CTL, 32'h0000_0007);
    grab(0, 40);
    chk("tx held", 32'h0000_0000, hist[31:0]);
    rd(0, OFS_CTL);
    chk("ctrl idle", 32'h0000_0007, r);
    wr(0, OFS_CTL, 32'h0000_0005);
    apb(OFS_PORT, 1'b1, {30'h0, FPW_1X});
    // lane 1 one-way at full rate, raw prbs7 on the wire
    wr(1, OFS_SERDES, 32'h0000_0e8f);
    wr(1, OFS_ERR, 32'h0000_0000);
    wr(1, OFS_SEED, 32'h0000_0055);
    wr(1, OFS_CTL, 32'h0000_000d);
    wr(1, OFS_CTL, 32'h0000_000f);
    grab(1, 68);
    chk("raw prbs7", 32'h0000_0000,
        {31'h0, |(hist[40:0] ^ hist[46:6] ^ hist[47:7])});
    chk("raw line live", 32'h0000_0001, {31'h0, |hist});
    hit(1);
    repeat (30) @(posedge link_clk);
    wr(1, OFS_CTL, 32'h0000_000b);
    repeat (40) @(posedge link_clk);
    rd(1, OFS_ERR);
    chk("one-way clean", 32'h0000_0000, r);
    hit(1);
    repeat (20) @(posedge link_clk);
    rd(1, OFS_ERR);
    chk("one-way hit", 32'h0000_0001, {31'h0, r != '0});
    wr(1, OFS_CTL, 32'h0000_0009);
    // lane 0 loopback: commas, then encoded data
    wr(0, OFS_ERR, 32'h0000_0000);
    wr(0, OFS_SEED, 32'h0000_00a5);
    wr(0, OFS_CTL, 32'h0000_0007);
    rd(0, OFS_CTL);
    chk("ctrl active", 32'h0000_0207, r);
    hist = '0;
    cg = '0;
    n = 0;
    while (cg !== K28_5_NEG)
    begin
      grab(0, 1);
      n++;
      if (n > 100)
        give_up("first comma");
    end
    for (int g = 1; g < 33; g++)
    begin
      grab(0, 10);
      if (g < 32)
        chk("comma", 32'(g[0] ? K28_5_POS : K28_5_NEG),
            32'(cg));
      else
        chk("data", 32'h0000_0000,
            {31'h0, cg === K28_5_NEG || cg === K28_5_POS});
    end
    repeat (100) @(posedge link_clk);
    wr(0, OFS_CTL, 32'h0000_0003);
    repeat (200) @(posedge link_clk);
    rd(0, OFS_ERR);
    chk("loop clean", 32'h0000_0000, r);
    hit(0);
    repeat (60) @(posedge link_clk);
    rd(0, OFS_ERR);
    chk("one flip", 1, {31'h0, r >= 32'h1 && r <= 32'h2});
    wr(0, OFS_CTL, 32'h0000_0001);
    repeat (4) @(posedge link_clk);
    rd(0, OFS_ERR);
    keep = r;
    hit(0);
    grab(0, 20);
    chk("tx stopped", 32'h0000_0000, {12'h0, hist[19:0]});
    rd(0, OFS_ERR);
    chk("count frozen", keep, r);
    rd(0, OFS_BITS);
    chk("bits whole groups", 0, r % BITS_PER_CG);
    chk("bits counted", 1, {31'h0, r != '0});
    wr(0, OFS_ERR, 32'h0000_0000);
    rd(0, OFS_ERR);
    chk("count cleared", 32'h0000_0000, r);
    wrap_up();
  end
endmodule // testbench
`default_nettype wire
